// [verilog/dmx_pkg.sv]
// constants and types for the dual mii port crossbar
`default_nettype none
package dmx_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_BCR_A = 8'h00;
	localparam logic [7:0] IDX_MAP_A = 8'h17;
	localparam logic [7:0] IDX_CHAN_STRIDE = 8'h20;
	localparam logic [7:0] IDX_STATUS = 8'h40;
	localparam int BYTE_SHIFT = 2;

	// basic_control_reg fields
	localparam int BCR_SPEED_BIT = 13;
	localparam int BCR_AUTONEG_BIT = 12;
	localparam int BCR_ISOLATE_BIT = 10;
	localparam int BCR_DUPLEX_BIT = 8;
	localparam logic [15:0] BCR_MASK = 16'h3500;
	localparam logic [15:0] BCR_RESET = 16'h0000;

	// port_map_bypass_control fields
	localparam int MAP_RX_LO = 11;
	localparam int MAP_TX_LO = 9;
	localparam int MAP_SCRX_BIT = 7;
	localparam int MAP_SCTX_BIT = 6;
	localparam int MAP_RMII_BIT = 5;
	localparam int MAP_THR_LO = 0;
	localparam logic [15:0] MAP_MASK = 16'h1ee3;
	localparam logic [15:0] MAP_RESET = 16'h0001;
	localparam logic [3:0] MAP_EXTENDER = 4'he;
	localparam logic [3:0] MAP_PORT_OFF = 4'hf;

	// transmit source field
	typedef enum logic [1:0] {
		TXSRC_OWN = 2'b00,
		TXSRC_OPP = 2'b01,
		TXSRC_RXPATH = 2'b10,
		TXSRC_OFF = 2'b11
	} dmx_txsrc_e;

	// receive destination field
	typedef enum logic [1:0] {
		RXDST_OWN = 2'b00,
		RXDST_OPP = 2'b01,
		RXDST_BOTH = 2'b10,
		RXDST_OFF = 2'b11
	} dmx_rxdst_e;

	// which channel feeds a port's receive outputs
	typedef enum logic [1:0] {
		RXSEL_OWN = 2'b00,
		RXSEL_OTHER = 2'b01,
		RXSEL_NONE = 2'b10
	} dmx_rxsel_e;

	typedef enum logic {
		ST_STRAP = 1'b0,
		ST_RUN = 1'b1
	} dmx_state_e;

	typedef enum logic [2:0] {
		REG_BCR_A = 3'h0,
		REG_MAP_A = 3'h1,
		REG_BCR_B = 3'h2,
		REG_MAP_B = 3'h3,
		REG_STATUS = 3'h4,
		REG_NONE = 3'h7
	} dmx_reg_e;

	typedef struct packed {
		logic [3:0] txd;
		logic tx_en;
	} dmx_tx_s;

	typedef struct packed {
		logic [3:0] rxd;
		logic rx_dv;
		logic rx_er;
		logic crs;
	} dmx_rx_s;
endpackage : dmx_pkg
`default_nettype wire

// [verilog/dmx_rx_port_sel.sv]
// receive source selection for one mii port
`default_nettype none
module dmx_rx_port_sel (
	input wire logic [1:0] own_dest,
	input wire logic [1:0] other_dest,
	input wire logic own_map_off,
	input wire dmx_pkg::dmx_rx_s own_rx,
	input wire dmx_pkg::dmx_rx_s other_rx,
	output dmx_pkg::dmx_rx_s port_rx,
	output dmx_pkg::dmx_rxsel_e sel
);
	import dmx_pkg::*;

	logic other_wants;

	// other channel reaches this port with opposite or both
	assign other_wants = (other_dest == RXDST_OPP) || (other_dest == RXDST_BOTH);

	always_comb begin
		sel = RXSEL_NONE;
		if (own_map_off) begin
			sel = RXSEL_NONE; // RL6
		end else begin
			case (own_dest)
				RXDST_OWN: sel = RXSEL_OWN; // RL23
				RXDST_BOTH: sel = (other_dest == RXDST_OPP) ? RXSEL_OTHER : RXSEL_OWN; // RL24
				RXDST_OPP: begin
					if (other_wants) begin
						sel = RXSEL_OTHER; // RL24
					end else if (other_dest == RXDST_OWN) begin
						sel = RXSEL_OWN;
					end else begin
						sel = RXSEL_NONE;
					end
				end
				RXDST_OFF: sel = other_wants ? RXSEL_OTHER : RXSEL_NONE; // RL24
				default: sel = RXSEL_NONE;
			endcase
		end
	end

	always_comb begin
		case (sel)
			RXSEL_OWN: port_rx = own_rx;
			RXSEL_OTHER: port_rx = other_rx;
			default: port_rx = '0;
		endcase
	end
endmodule : dmx_rx_port_sel
`default_nettype wire

// [verilog/dmx_crossbar.sv]
// dual mii port crossbar with apb registers and strap loading
// Operation
// RL1 - transmit source: own, opposite, other rx, off
// RL2 - 0101 on both swaps the ports
// RL3 - 1110 on both loops rx into tx
// RL4 - 00/01 tx fields broadcast one port
// RL5 - 10/11 rx fields mirror one channel
// RL6 - map field 1111 disables own port
// RL7 - extender strap configures both channels itself
// RL8 - extender without rmii strap selects single clock
// RL9 - strap variants: copper, fiber, media converter
// RL10 - far side keeps speeds, duplex, clocking equal
// RL11 - far side sets single clock per path
// RL12 - far side: media conversion only 100Mb
// RL13 - far side: broadcast needs matching clocking
// RL14 - shared single clock tx: collision jams both
// RL15 - far side: rmii set on both together
// RL16 - far side: no serial mode when sharing
// RL17 - carrier sense follows tx or rx map
// RL18 - output enables stay with own channel
// RL19 - far side: energy detect off when remapped
// RL20 - indicators report own channel only
// RL21 - each strap configures its own channel
// RL22 - port isolate from own channel's control
// RL23 - receive destination: own, opposite, both, none
// RL24 - port owner yields only when routed away; code also yields when own is both and other is opposite
// RL25 - disabled tx source holds tx enable low
`default_nettype none
module dmx_crossbar #(
	parameter int ADDR_W = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic extender_strap,
	input wire logic [1:0] rmii_strap,
	input wire logic [1:0] autoneg_strap,
	input wire logic [1:0] autoneg_select_strap_0,
	input wire logic [1:0] autoneg_select_strap_1,
	input wire logic [1:0] optical_mode_strap,
	input wire dmx_pkg::dmx_tx_s [1:0] mac_tx,
	output dmx_pkg::dmx_rx_s [1:0] port_rx,
	output logic [1:0] port_col,
	output logic [1:0] port_oe,
	input wire dmx_pkg::dmx_rx_s [1:0] chan_rx,
	input wire logic [1:0] chan_crs_tx,
	input wire logic [1:0] chan_col,
	input wire logic [1:0] chan_energy_off,
	output dmx_pkg::dmx_tx_s [1:0] chan_tx,
	output logic [1:0] chan_jam,
	output logic [1:0] chan_autoneg_en,
	output logic [1:0] chan_speed_100,
	output logic [1:0] chan_full_duplex,
	output logic [1:0] chan_fiber_en,
	output logic [1:0] chan_rmii_en,
	output logic [1:0] single_clock_rx_enable,
	output logic [1:0] single_clock_tx_enable,
	output logic [3:0] chan_elastic_threshold,
	input wire logic [1:0] chan_link,
	input wire logic [1:0] chan_speed,
	input wire logic [1:0] chan_activity,
	output logic link_indicator_chan_a,
	output logic link_indicator_chan_b,
	output logic [1:0] speed_indicator,
	output logic [1:0] activity_indicator
);
	import dmx_pkg::*;

	initial begin
		if (ADDR_W < 10 || ADDR_W > 32) begin
			$error("ADDR_W must be 10 to 32");
		end
	end

	dmx_state_e state;
	logic [15:0] bcr [2];
	logic [15:0] map [2];
	logic ext_latched;
	logic [1:0] rmii_latched;
	logic [1:0] fiber_latched;
	dmx_rxsel_e rx_sel [2];
	dmx_rx_s next_port_rx [2];
	dmx_reg_e acc_reg;
	logic wr_go;
	logic tx_shared;
	logic [15:0] next_rdata;

	// maps a byte address onto a register
	function automatic dmx_reg_e reg_of(input logic [ADDR_W-1:0] a);
		logic [7:0] idx;
		idx = a[BYTE_SHIFT +: 8];
		reg_of = REG_NONE;
		if (a[BYTE_SHIFT-1:0] == '0 && (a >> (BYTE_SHIFT + 8)) == '0) begin
			if (idx == IDX_BCR_A) reg_of = REG_BCR_A;
			else if (idx == IDX_MAP_A) reg_of = REG_MAP_A;
			else if (idx == IDX_BCR_A + IDX_CHAN_STRIDE) reg_of = REG_BCR_B;
			else if (idx == IDX_MAP_A + IDX_CHAN_STRIDE) reg_of = REG_MAP_B;
			else if (idx == IDX_STATUS) reg_of = REG_STATUS;
		end
	endfunction : reg_of

	// true when channel c transmits from mii port p
	function automatic logic uses_port(input logic [1:0] src, input int c, input int p);
		uses_port = (c == p) ? (src == TXSRC_OWN) : (src == TXSRC_OPP);
	endfunction : uses_port

	assign acc_reg = reg_of(paddr);
	assign wr_go = psel & penable & pready & pwrite & (acc_reg != REG_NONE) & (acc_reg != REG_STATUS);
	// both channels fed from one mac port
	assign tx_shared = (map[0][MAP_TX_LO +: 2] == TXSRC_OWN && map[1][MAP_TX_LO +: 2] == TXSRC_OPP) ||
		(map[0][MAP_TX_LO +: 2] == TXSRC_OPP && map[1][MAP_TX_LO +: 2] == TXSRC_OWN);

	// straps are caught on the first edge after reset release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_STRAP;
			ext_latched <= 1'b0;
			rmii_latched <= 2'b00;
			fiber_latched <= 2'b00;
		end else if (state == ST_STRAP) begin
			state <= ST_RUN;
			ext_latched <= extender_strap;
			rmii_latched <= rmii_strap; // RL21
			fiber_latched <= optical_mode_strap; // RL21
		end
	end

	generate
		for (genvar c = 0; c < 2; c++) begin : g_chan
			localparam int O = 1 - c;
			logic [1:0] src;
			logic [15:0] strap_bcr;
			logic [15:0] strap_map;

			assign src = map[c][MAP_TX_LO +: 2];

			// per-channel strap defaults
			always_comb begin
				strap_bcr = BCR_RESET;
				if (optical_mode_strap[c]) begin
					strap_bcr[BCR_SPEED_BIT] = 1'b1; // RL9
					strap_bcr[BCR_DUPLEX_BIT] = 1'b1;
				end else if (autoneg_strap[c]) begin
					strap_bcr[BCR_AUTONEG_BIT] = 1'b1;
				end else begin
					strap_bcr[BCR_SPEED_BIT] = autoneg_select_strap_0[c]; // RL9
					strap_bcr[BCR_DUPLEX_BIT] = autoneg_select_strap_1[c]; // RL9
				end
				strap_map = MAP_RESET;
				strap_map[MAP_RMII_BIT] = rmii_strap[c];
				if (extender_strap) begin
					strap_map[MAP_TX_LO +: 4] = MAP_EXTENDER; // RL7
					strap_map[MAP_SCRX_BIT] = ~rmii_strap[c]; // RL8
					strap_map[MAP_SCTX_BIT] = ~rmii_strap[c]; // RL8
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					bcr[c] <= BCR_RESET;
				end else if (state == ST_STRAP) begin
					bcr[c] <= strap_bcr;
				end else if (wr_go && acc_reg == (c == 0 ? REG_BCR_A : REG_BCR_B)) begin
					bcr[c] <= pwdata[15:0] & BCR_MASK;
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					map[c] <= MAP_RESET;
				end else if (state == ST_STRAP) begin
					map[c] <= strap_map; // RL7
				end else if (wr_go && acc_reg == (c == 0 ? REG_MAP_A : REG_MAP_B)) begin
					map[c] <= pwdata[15:0] & MAP_MASK;
				end
			end

			// transmit path of channel c
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					chan_tx[c] <= '0;
				end else begin
					case (src)
						TXSRC_OWN: chan_tx[c] <= mac_tx[c]; // RL1
						TXSRC_OPP: chan_tx[c] <= mac_tx[O]; // RL4
						TXSRC_RXPATH: chan_tx[c] <= {chan_rx[O].rxd, chan_rx[O].rx_dv}; // RL3
						default: chan_tx[c] <= '0; // RL25
					endcase
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					chan_jam[c] <= 1'b0;
				end else begin
					chan_jam[c] <= tx_shared & map[c][MAP_SCTX_BIT] & (|chan_col); // RL14
				end
			end

			dmx_rx_port_sel u_sel (
				.own_dest(map[c][MAP_RX_LO +: 2]),
				.other_dest(map[O][MAP_RX_LO +: 2]),
				.own_map_off(map[c][MAP_TX_LO +: 4] == MAP_PORT_OFF),
				.own_rx(chan_rx[c]),
				.other_rx(chan_rx[O]),
				.port_rx(next_port_rx[c]),
				.sel(rx_sel[c])
			);

			// receive outputs, carrier sense and collision of mii port c
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					port_rx[c] <= '0;
					port_col[c] <= 1'b0;
				end else begin
					port_rx[c] <= next_port_rx[c]; // RL2 RL5
					if (!map[c][MAP_RMII_BIT]) begin
						port_rx[c].crs <= (uses_port(map[c][MAP_TX_LO +: 2], c, c) & chan_crs_tx[c]) |
							(uses_port(map[O][MAP_TX_LO +: 2], O, c) & chan_crs_tx[O]); // RL17
					end
					port_col[c] <= (uses_port(map[c][MAP_TX_LO +: 2], c, c) & chan_col[c]) |
						(uses_port(map[O][MAP_TX_LO +: 2], O, c) & chan_col[O]);
				end
			end

			// enables and indicators never follow the mapping
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					port_oe[c] <= 1'b0;
					speed_indicator[c] <= 1'b0;
					activity_indicator[c] <= 1'b0;
				end else begin
					port_oe[c] <= ~chan_energy_off[c] & ~bcr[c][BCR_ISOLATE_BIT]; // RL18 RL22
					speed_indicator[c] <= chan_speed[c]; // RL20
					activity_indicator[c] <= chan_activity[c]; // RL20
				end
			end

			// channel configuration outputs
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					chan_autoneg_en[c] <= 1'b0;
					chan_speed_100[c] <= 1'b0;
					chan_full_duplex[c] <= 1'b0;
					chan_fiber_en[c] <= 1'b0;
					chan_rmii_en[c] <= 1'b0;
					single_clock_rx_enable[c] <= 1'b0;
					single_clock_tx_enable[c] <= 1'b0;
					chan_elastic_threshold[2*c +: 2] <= 2'b00;
				end else begin
					chan_autoneg_en[c] <= bcr[c][BCR_AUTONEG_BIT];
					chan_speed_100[c] <= bcr[c][BCR_SPEED_BIT];
					chan_full_duplex[c] <= bcr[c][BCR_DUPLEX_BIT];
					chan_fiber_en[c] <= fiber_latched[c]; // RL9
					chan_rmii_en[c] <= map[c][MAP_RMII_BIT];
					single_clock_rx_enable[c] <= map[c][MAP_SCRX_BIT];
					single_clock_tx_enable[c] <= map[c][MAP_SCTX_BIT];
					chan_elastic_threshold[2*c +: 2] <= map[c][MAP_THR_LO +: 2];
				end
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_indicator_chan_a <= 1'b0;
			link_indicator_chan_b <= 1'b0;
		end else begin
			link_indicator_chan_a <= chan_link[0]; // RL20
			link_indicator_chan_b <= chan_link[1]; // RL20
		end
	end

	// read data for the addressed register
	always_comb begin
		case (acc_reg)
			REG_BCR_A: next_rdata = bcr[0];
			REG_MAP_A: next_rdata = map[0];
			REG_BCR_B: next_rdata = bcr[1];
			REG_MAP_B: next_rdata = map[1];
			REG_STATUS: next_rdata = {5'h00, chan_jam, rx_sel[1], rx_sel[0], rmii_latched, fiber_latched,
				ext_latched};
			default: next_rdata = 16'h0000;
		endcase
	end

	// apb answer one cycle into the access phase, once straps are in
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel & penable & ~pready & (state == ST_RUN);
			if (psel && penable && !pready && state == ST_RUN) begin
				pslverr <= (acc_reg == REG_NONE) || (pwrite && acc_reg == REG_STATUS);
				prdata <= pwrite ? 32'h0000_0000 : {16'h0000, next_rdata};
			end else begin
				pslverr <= 1'b0;
			end
		end
	end
endmodule : dmx_crossbar
`default_nettype wire

// [testbench/dmx_crossbar_chk.sv]
// port assertions for the crossbar
`default_nettype none
module dmx_crossbar_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [1:0] port_oe,
	input wire logic [1:0] chan_energy_off,
	input wire logic [1:0] chan_col,
	input wire logic [1:0] chan_jam,
	input wire logic link_indicator_chan_a,
	input wire logic link_indicator_chan_b,
	input wire logic [1:0] chan_link,
	input wire logic [1:0] activity_indicator,
	input wire logic [1:0] chan_activity,
	input wire logic [1:0] speed_indicator,
	input wire logic [1:0] chan_speed
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_settled;
		$past(presetn, 3);
	endsequence
	sequence s_access;
		psel && penable && !pready;
	endsequence
	a_ready_timing: assert property (s_settled and s_access |=> pready) else $error("pready late");
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
	a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
	a_write_rdata: assert property (pready && pwrite |-> prdata == 32'h0) else $error("prdata on write");
	a_oe_own: assert property (s_settled |-> (port_oe & $past(chan_energy_off)) == 2'b00)
		else $error("oe not from own channel");
	a_link_own: assert property (s_settled |-> {link_indicator_chan_b, link_indicator_chan_a} == $past(chan_link))
		else $error("link indicator wrong");
	a_speed_own: assert property (s_settled |-> speed_indicator == $past(chan_speed))
		else $error("speed indicator wrong");
	a_act_own: assert property (s_settled |-> activity_indicator == $past(chan_activity))
		else $error("activity indicator wrong");
	a_jam_cause: assert property (chan_jam != 2'b00 |-> $past(chan_col) != 2'b00)
		else $error("jam without collision");
endmodule : dmx_crossbar_chk
bind dmx_crossbar dmx_crossbar_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
	.port_oe, .chan_energy_off, .chan_col, .chan_jam, .link_indicator_chan_a, .link_indicator_chan_b, .chan_link,
	.activity_indicator, .chan_activity, .speed_indicator, .chan_speed);
`default_nettype wire

// [testbench/dmx_mac_model.sv]
// mac model driving both transmit ports
`default_nettype none
module dmx_mac_model (
	input wire logic pclk,
	input wire logic presetn,
	output dmx_pkg::dmx_tx_s [1:0] mac_tx
);
	timeunit 1ns;
	timeprecision 1ps;
	import dmx_pkg::*;
	logic [3:0] cnt;
	// nibbles change every cycle so a stale route shows
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 4'h0;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
	assign mac_tx[0] = {cnt, 1'b1};
	assign mac_tx[1] = {~cnt, cnt[0]};
endmodule : dmx_mac_model
`default_nettype wire

// [testbench/tb_dual_mii_port_crossbar.sv]
// testbench for the dual mii port crossbar
`default_nettype none
module tb_dual_mii_port_crossbar;
	timeunit 1ns;
	timeprecision 1ps;
	import dmx_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, extender_strap, err, ed_on;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] rmii_strap, port_col, port_oe, chan_crs_tx, chan_col, chan_energy_off, chan_jam;
	logic [1:0] single_clock_rx_enable, chan_link, chan_activity, st;
	logic [1:0] autoneg_strap, autoneg_select_strap_0, autoneg_select_strap_1, optical_mode_strap, chan_speed_100;
	logic [1:0] chan_full_duplex, chan_fiber_en, chan_autoneg_en, chan_rmii_en, single_clock_tx_enable;
	logic [3:0] chan_elastic_threshold;
	dmx_tx_s [1:0] mac_tx, chan_tx;
	dmx_rx_s [1:0] port_rx, chan_rx;
	int err_count = 0;
	int n_tests = 0;
	dmx_crossbar dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.extender_strap, .rmii_strap, .autoneg_strap, .autoneg_select_strap_0, .autoneg_select_strap_1,
		.optical_mode_strap, .mac_tx, .port_rx, .port_col, .port_oe, .chan_rx, .chan_crs_tx, .chan_col,
		.chan_energy_off, .chan_tx, .chan_jam, .chan_autoneg_en, .chan_speed_100, .chan_full_duplex,
		.chan_fiber_en, .chan_rmii_en, .single_clock_rx_enable, .single_clock_tx_enable, .chan_elastic_threshold,
		.chan_link, .chan_speed(st), .chan_activity, .link_indicator_chan_a(), .link_indicator_chan_b(),
		.speed_indicator(), .activity_indicator());
	dmx_mac_model u_mac (.pclk, .presetn, .mac_tx);
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		st <= st + 2'b01;
		chan_link <= st;
		chan_activity <= ~st;
		chan_energy_off <= {1'b0, st[1] & ed_on};
	end
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// pready is read at the edge, before that edge's updates land
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rst();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
	endtask : rst
	task automatic setmap(input logic [15:0] a, input logic [15:0] b);
		apb(1'b1, 12'h05c, {16'h0, a});
		apb(1'b1, 12'h0dc, {16'h0, b});
		repeat (3) @(posedge pclk);
	endtask : setmap
	// s: 0 port a, 1 port b, 2 other channel rx, 3 off
	task automatic txchk(input int c, input int s);
		logic [4:0] e;
		@(negedge pclk);
		e = s < 2 ? mac_tx[s] : s == 2 ? {chan_rx[1-c].rxd, chan_rx[1-c].rx_dv} : 5'h00;
		@(posedge pclk);
		#1;
		chk("chan_tx", {11'h0, e}, {11'h0, chan_tx[c]});
	endtask : txchk
	// carrier bit left out, it follows its own rules
	task automatic rxchk(input int p, input int c);
		chk("port_rx", c < 2 ? {10'h0, chan_rx[c][6:1]} : 16'h0, {10'h0, port_rx[p][6:1]});
	endtask : rxchk
	task automatic t_regs();
		apb(1'b0, 12'h05c, 32'h0);
		chk("map_a", 16'h0001, rd[15:0]);
		apb(1'b0, 12'h3fc, 32'h0);
		chk("unmapped_err", 16'h1, {15'h0, err});
		apb(1'b1, 12'h100, 32'h1);
		chk("status_err", 16'h1, {15'h0, err});
		apb(1'b1, 12'h000, 32'h0000_0400);
		apb(1'b0, 12'h000, 32'h0);
		chk("bcr_a", 16'h0400, rd[15:0]);
		chk("port_oe_a", 16'h0, {15'h0, port_oe[0]});
		apb(1'b1, 12'h000, 32'h0);
		ed_on <= 1'b0;
	endtask : t_regs
	task automatic t_txsrc();
		for (int s = 0; s < 4; s++) begin
			setmap(16'h0041 | 16'(s << 9), 16'h00c1);
			txchk(0, s);
		end
	endtask : t_txsrc
	task automatic t_swap();
		setmap(16'h0a01, 16'h0a01);
		rxchk(0, 1);
		rxchk(1, 0);
		txchk(0, 1);
		txchk(1, 0);
	endtask : t_swap
	task automatic t_ext();
		setmap(16'h1c21, 16'h1c21);
		rxchk(0, 2);
		rxchk(1, 2);
		txchk(0, 2);
		txchk(1, 2);
	endtask : t_ext
	task automatic t_bcast();
		setmap(16'h0041, 16'h0241);
		txchk(0, 0);
		txchk(1, 0);
		@(posedge pclk);
		chan_col <= 2'b01;
		repeat (3) @(posedge pclk);
		#1;
		chk("chan_jam", 16'h3, {14'h0, chan_jam});
		chk("port_col", 16'h1, {14'h0, port_col});
		chk("port_crs", 16'h1, {14'h0, port_rx[1].crs, port_rx[0].crs});
		@(posedge pclk);
		chan_col <= 2'b00;
		setmap(16'h0201, 16'h0001);
		txchk(0, 1);
		txchk(1, 1);
	endtask : t_bcast
	task automatic t_mirror();
		setmap(16'h1001, 16'h1801);
		rxchk(0, 0);
		rxchk(1, 0);
		setmap(16'h1801, 16'h1001);
		rxchk(0, 1);
		rxchk(1, 1);
	endtask : t_mirror
	task automatic t_off();
		setmap(16'h1e01, 16'h0801);
		rxchk(0, 2);
		rxchk(1, 2);
		txchk(0, 3);
	endtask : t_off
	task automatic t_strap();
		extender_strap <= 1'b1;
		rmii_strap <= 2'b00;
		autoneg_select_strap_0 <= 2'b01;
		autoneg_select_strap_1 <= 2'b01;
		optical_mode_strap <= 2'b10;
		rst();
		apb(1'b0, 12'h0dc, 32'h0);
		chk("map_b_ext", 16'h1cc1, rd[15:0]);
		chk("sc_rx", 16'h3, {14'h0, single_clock_rx_enable});
		chk("strap_cfg", 16'h00f8, {8'h0, chan_speed_100, chan_full_duplex, chan_fiber_en, chan_autoneg_en});
		chk("clk_cfg", 16'h0035, {8'h0, chan_rmii_en, single_clock_tx_enable, chan_elastic_threshold});
		apb(1'b0, 12'h100, 32'h0);
		chk("status", 16'h0145, rd[15:0]);
	endtask : t_strap
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : conclude
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, extender_strap, st, paddr, pwdata, rmii_strap, chan_col} = '0;
		{chan_link, chan_activity, chan_energy_off} = '0;
		{autoneg_strap, autoneg_select_strap_0, autoneg_select_strap_1, optical_mode_strap} = '0;
		ed_on = 1'b1;
		chan_crs_tx = 2'b01;
		chan_rx[0] = 7'h1c;
		chan_rx[1] = 7'h66;
		rst();
		t_regs();
		t_txsrc();
		t_swap();
		t_ext();
		t_bcast();
		t_mirror();
		t_off();
		t_strap();
		conclude();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		err_count++;
		conclude();
	end
endmodule : tb_dual_mii_port_crossbar
`default_nettype wire
